// *** common/cfsse_defines.vh ***
// Constants for the flag, shift, subtract and stop execution slice
`ifndef CFSSE_DEFINES_VH
`define CFSSE_DEFINES_VH
// ---------------------------------------------------------------
// Opcodes
// ---------------------------------------------------------------
`define CFSSE_OPC_SET_CARRY   8'hDF
`define CFSSE_OPC_ASHR_DIR    8'hD0
`define CFSSE_OPC_ASHR_IND    8'hD1
`define CFSSE_OPC_PTR_LOAD    8'h31
`define CFSSE_OPC_STOP        8'h7F
`define CFSSE_OPC_SUB_WW      8'h22
`define CFSSE_OPC_SUB_WI      8'h23
`define CFSSE_OPC_SUB_GG      8'h24
`define CFSSE_OPC_SUB_GI      8'h25
`define CFSSE_OPC_SUB_GM      8'h26
// ---------------------------------------------------------------
// Execution times in clock cycles
// ---------------------------------------------------------------
`define CFSSE_CYC_SHORT       4'h6
`define CFSSE_CYC_LONG        4'hA
`define CFSSE_CYC_STOP        4'h3
// ---------------------------------------------------------------
// ALU operations
// ---------------------------------------------------------------
`define CFSSE_ALU_SUB         2'h0
`define CFSSE_ALU_ASHR        2'h1
`define CFSSE_ALU_SET_CARRY   2'h2
`define CFSSE_ALU_PASS        2'h3
// ---------------------------------------------------------------
// Data space and pointers
// ---------------------------------------------------------------
`define CFSSE_PTR0_ADDR       8'hD6
`define CFSSE_PTR1_ADDR       8'hD7
`define CFSSE_PTR0_RST        8'hC0
`define CFSSE_PTR1_RST        8'hC8
`define CFSSE_WORK_PAGE       4'hC
// ---------------------------------------------------------------
// Flag bit positions
// ---------------------------------------------------------------
`define CFSSE_FLAG_C          7
`define CFSSE_FLAG_Z          6
`define CFSSE_FLAG_S          5
`define CFSSE_FLAG_V          4
`define CFSSE_FLAG_D          3
`define CFSSE_FLAG_H          2
`define CFSSE_FLAGS_RST       8'h00
// ---------------------------------------------------------------
// Bus register byte offsets and responses
// ---------------------------------------------------------------
`define CFSSE_REG_CMD         6'h00
`define CFSSE_REG_STATUS      6'h04
`define CFSSE_REG_FLAGS       6'h08
`define CFSSE_REG_MEM_ADDR    6'h0C
`define CFSSE_REG_MEM_DATA    6'h10
`define CFSSE_RESP_OKAY       2'h0
`define CFSSE_RESP_SLVERR     2'h2
`endif

// *** hdl/cfsse_mem.v ***
// Data space byte memory with a registered read port
`timescale 1ns/100ps
module cfsse_mem #(
   parameter AW = 8,
   parameter DW = 8
) (
   input  wire          aclk,
   input  wire          we,
   input  wire [AW-1:0] waddr,
   input  wire [DW-1:0] wdata,
   input  wire [AW-1:0] raddr,
   output reg  [DW-1:0] rdata_q
);
   // No reset: contents survive a reset taken to leave stop mode
   reg [DW-1:0] mem [0:(1<<AW)-1];

   always @(posedge aclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata_q <= mem[raddr];
   end
endmodule

// *** hdl/cfsse_alu.v ***
// Result and flag computation for subtract, shift and set-carry
`include "cfsse_defines.vh"
`timescale 1ns/100ps
module cfsse_alu (
   input  wire [1:0] op,
   input  wire [7:0] dst,
   input  wire [7:0] src,
   input  wire [7:0] flags_in,
   output reg  [7:0] result,
   output reg  [7:0] flags_out
);
   reg [8:0] diff;
   reg [4:0] low;

   always @* begin
      diff      = {1'b0, dst} - {1'b0, src};
      // Two's complement add exposes the nibble carry directly
      low       = {1'b0, dst[3:0]} + {1'b0, ~src[3:0]} + 5'h01;
      result    = dst;
      flags_out = flags_in;
      case (op)
         `CFSSE_ALU_SUB: begin
            result                    = diff[7:0];
            flags_out[`CFSSE_FLAG_C]  = diff[8];
            flags_out[`CFSSE_FLAG_Z]  = (diff[7:0] == 8'h00);
            flags_out[`CFSSE_FLAG_S]  = diff[7];
            flags_out[`CFSSE_FLAG_V]  = (dst[7] ^ src[7]) & (diff[7] == src[7]);
            flags_out[`CFSSE_FLAG_D]  = 1'b1;
            flags_out[`CFSSE_FLAG_H]  = ~low[4];
         end
         `CFSSE_ALU_ASHR: begin
            result                    = {dst[7], dst[7:1]};
            flags_out[`CFSSE_FLAG_C]  = dst[0];
            flags_out[`CFSSE_FLAG_Z]  = (dst[7:1] == 7'h00) & ~dst[7];
            flags_out[`CFSSE_FLAG_S]  = dst[7];
            flags_out[`CFSSE_FLAG_V]  = 1'b0;
         end
         `CFSSE_ALU_SET_CARRY: begin
            flags_out[`CFSSE_FLAG_C]  = 1'b1;
         end
         default: begin
            result    = dst;
            flags_out = flags_in;
         end
      endcase
   end
endmodule

// *** hdl/cfsse_exec.v ***
// Execution slice: set carry, arithmetic shift, pointer load, stop, subtract
//
// Decided for this implementation: the AXI4-Lite register port.
`include "cfsse_defines.vh"
`timescale 1ns/100ps
module cfsse_exec #(
   parameter ADDR_W = 6
) (
   input  wire              aclk,
   input  wire              aresetn,
   input  wire [ADDR_W-1:0] s_axi_awaddr,
   input  wire              s_axi_awvalid,
   output wire              s_axi_awready,
   input  wire [31:0]       s_axi_wdata,
   input  wire [3:0]        s_axi_wstrb,
   input  wire              s_axi_wvalid,
   output wire              s_axi_wready,
   output wire [1:0]        s_axi_bresp,
   output wire              s_axi_bvalid,
   input  wire              s_axi_bready,
   input  wire [ADDR_W-1:0] s_axi_araddr,
   input  wire              s_axi_arvalid,
   output wire              s_axi_arready,
   output wire [31:0]       s_axi_rdata,
   output wire [1:0]        s_axi_rresp,
   output wire              s_axi_rvalid,
   input  wire              s_axi_rready,
   output wire              cpu_clk_en,
   output wire              sys_clk_en,
   output wire              stop_mode,
   output wire              busy
);
   // ---------------------------------------------------------------
   // States
   // ---------------------------------------------------------------
   localparam [2:0] S_IDLE = 3'h0;
   localparam [2:0] S_IND  = 3'h1;
   localparam [2:0] S_ADR  = 3'h2;
   localparam [2:0] S_SRC  = 3'h3;
   localparam [2:0] S_DST  = 3'h4;
   localparam [2:0] S_EXE  = 3'h5;
   localparam [2:0] S_WAIT = 3'h6;
   localparam [2:0] S_STOP = 3'h7;

   // ---------------------------------------------------------------
   // Decode functions
   // ---------------------------------------------------------------
   // Zero means the opcode is not executed by this slice
   function [3:0] op_cycles;
      input [7:0] opc;
      begin
         case (opc)
            `CFSSE_OPC_SET_CARRY, `CFSSE_OPC_ASHR_DIR, `CFSSE_OPC_ASHR_IND,
            `CFSSE_OPC_PTR_LOAD, `CFSSE_OPC_SUB_WW, `CFSSE_OPC_SUB_WI: op_cycles = `CFSSE_CYC_SHORT;
            `CFSSE_OPC_SUB_GG, `CFSSE_OPC_SUB_GI, `CFSSE_OPC_SUB_GM:  op_cycles = `CFSSE_CYC_LONG;
            `CFSSE_OPC_STOP:                                           op_cycles = `CFSSE_CYC_STOP;
            default:                                                   op_cycles = 4'h0;
         endcase
      end
   endfunction

   function [2:0] op_first;
      input [7:0] opc;
      begin
         case (opc)
            `CFSSE_OPC_SET_CARRY, `CFSSE_OPC_PTR_LOAD:                  op_first = S_EXE;
            `CFSSE_OPC_ASHR_IND, `CFSSE_OPC_SUB_WI, `CFSSE_OPC_SUB_GI: op_first = S_IND;
            `CFSSE_OPC_STOP:                                          op_first = S_WAIT;
            default:                                                  op_first = S_SRC;
         endcase
      end
   endfunction

   // Working register r selects a window of eight behind either pointer
   function [7:0] work_addr;
      input [3:0] r;
      input [7:0] p0;
      input [7:0] p1;
      begin
         work_addr = r[3] ? {p1[7:3], r[2:0]} : {p0[7:3], r[2:0]};
      end
   endfunction

   function [7:0] reg_addr;
      input [7:0] a;
      input [7:0] p0;
      input [7:0] p1;
      begin
         reg_addr = (a[7:4] == `CFSSE_WORK_PAGE) ? work_addr(a[3:0], p0, p1) : a;
      end
   endfunction

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   reg [2:0]        state_q;
   reg [3:0]        cnt_q;
   reg [3:0]        cyc_q;
   reg [23:0]       instr_q;
   reg [7:0]        flags_q;
   reg [7:0]        ptr0_q;
   reg [7:0]        ptr1_q;
   reg [7:0]        eff_q;
   reg [7:0]        src_q;
   reg [7:0]        rd_addr_q;
   reg [7:0]        mem_addr_q;
   reg              illegal_q;
   reg              clk_en_q;
   reg              aw_got_q;
   reg              w_got_q;
   reg [ADDR_W-1:0] aw_addr_q;
   reg [31:0]       w_data_q;
   reg [3:0]        w_strb_q;
   reg              bvalid_q;
   reg [1:0]        bresp_q;
   reg              rvalid_q;
   reg [1:0]        rresp_q;
   reg [31:0]       rdata_q;

   wire [7:0] mem_q;
   wire [7:0] alu_res;
   wire [7:0] alu_flags;
   wire       stopped = (state_q == S_STOP);
   wire       busy_w  = (state_q != S_IDLE) && !stopped;

   // ---------------------------------------------------------------
   // Operand addressing
   // ---------------------------------------------------------------
   wire [7:0] opc     = instr_q[7:0];
   wire [7:0] b1      = instr_q[15:8];
   wire [7:0] b2      = instr_q[23:16];
   wire       short_f = (opc == `CFSSE_OPC_SUB_WW) || (opc == `CFSSE_OPC_SUB_WI);
   wire       gg_f    = (opc == `CFSSE_OPC_SUB_GG) || (opc == `CFSSE_OPC_SUB_GI);
   wire       imm_f   = (opc == `CFSSE_OPC_SUB_GM);
   wire       src_ind = (opc == `CFSSE_OPC_SUB_WI) || (opc == `CFSSE_OPC_SUB_GI);
   wire       dst_ind = (opc == `CFSSE_OPC_ASHR_IND);
   wire       is_ashr = (opc == `CFSSE_OPC_ASHR_DIR) || dst_ind;
   wire       is_sub  = short_f || gg_f || imm_f;
   wire [7:0] src_dir = short_f ? work_addr(b1[3:0], ptr0_q, ptr1_q) : reg_addr(b1, ptr0_q, ptr1_q);
   wire [7:0] dst_dir = short_f ? work_addr(b1[7:4], ptr0_q, ptr1_q) :
                        gg_f ? reg_addr(b2, ptr0_q, ptr1_q) : reg_addr(b1, ptr0_q, ptr1_q);
   wire [7:0] ind_adr = dst_ind ? dst_dir : src_dir;
   wire [7:0] src_ea  = src_ind ? eff_q : src_dir;
   wire [7:0] dst_ea  = dst_ind ? eff_q : dst_dir;

   // Pointer bytes live in flops but read back through the data space
   wire [7:0] mem_byte = (rd_addr_q == `CFSSE_PTR0_ADDR) ? ptr0_q :
                         (rd_addr_q == `CFSSE_PTR1_ADDR) ? ptr1_q : mem_q;

   reg [7:0] raddr;
   always @* begin
      case (state_q)
         S_IND:   raddr = ind_adr;
         S_SRC:   raddr = src_ea;
         S_DST:   raddr = dst_ea;
         default: raddr = mem_addr_q;
      endcase
   end

   // ---------------------------------------------------------------
   // Bus write channel
   // ---------------------------------------------------------------
   assign s_axi_awready = !aw_got_q && !bvalid_q;
   assign s_axi_wready  = !w_got_q && !bvalid_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;

   wire wr_fire  = aw_got_q && w_got_q && !bvalid_q;
   wire wr_cmd   = wr_fire && (aw_addr_q == `CFSSE_REG_CMD);
   wire wr_flags = wr_fire && (aw_addr_q == `CFSSE_REG_FLAGS);
   wire wr_maddr = wr_fire && (aw_addr_q == `CFSSE_REG_MEM_ADDR);
   wire wr_mdata = wr_fire && (aw_addr_q == `CFSSE_REG_MEM_DATA);
   wire wr_known = wr_cmd || wr_flags || wr_maddr || wr_mdata ||
                   (aw_addr_q == `CFSSE_REG_STATUS);
   // Stopped device refuses every change so its state is retained
   wire wr_lock  = busy_w || stopped;
   wire start    = wr_cmd && !wr_lock && w_strb_q[0] && (op_cycles(w_data_q[7:0]) != 4'h0);

   wire       exe_we   = (state_q == S_EXE) && (is_ashr || is_sub);
   wire       bus_we   = wr_mdata && !wr_lock && w_strb_q[0];
   wire       mem_we   = exe_we || bus_we;
   wire [7:0] mem_wa   = exe_we ? dst_ea : mem_addr_q;
   wire [7:0] mem_wd   = exe_we ? alu_res : w_data_q[7:0];

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_q  <= 1'b0;
         w_got_q   <= 1'b0;
         aw_addr_q <= {ADDR_W{1'b0}};
         w_data_q  <= 32'h00000000;
         w_strb_q  <= 4'h0;
         bvalid_q  <= 1'b0;
         bresp_q   <= `CFSSE_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_q  <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_q  <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_got_q <= 1'b0;
            w_got_q  <= 1'b0;
            bvalid_q <= 1'b1;
            // Address register stays writable while busy, only stop refuses it
            if (!wr_known || (wr_lock && (aw_addr_q != `CFSSE_REG_STATUS) && !(wr_maddr && !stopped))) begin
               bresp_q <= `CFSSE_RESP_SLVERR;
            end else begin
               bresp_q <= `CFSSE_RESP_OKAY;
            end
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Bus read channel
   // ---------------------------------------------------------------
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rresp   = rresp_q;
   assign s_axi_rdata   = rdata_q;

   always @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rresp_q  <= `CFSSE_RESP_OKAY;
         rdata_q  <= 32'h00000000;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_q <= 1'b1;
         rresp_q  <= `CFSSE_RESP_OKAY;
         case (s_axi_araddr)
            `CFSSE_REG_CMD:      rdata_q <= {8'h00, instr_q};
            `CFSSE_REG_STATUS:   rdata_q <= {16'h0000, flags_q, 5'h00, illegal_q, stopped, busy_w};
            `CFSSE_REG_FLAGS:    rdata_q <= {24'h000000, flags_q};
            `CFSSE_REG_MEM_ADDR: rdata_q <= {24'h000000, mem_addr_q};
            `CFSSE_REG_MEM_DATA: begin
               rdata_q <= {24'h000000, mem_byte};
               if (busy_w) begin
                  rresp_q <= `CFSSE_RESP_SLVERR;
               end
            end
            default: begin
               rdata_q <= 32'h00000000;
               rresp_q <= `CFSSE_RESP_SLVERR;
            end
         endcase
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   always @(posedge aclk) begin
      // Reset is the only way out of stop; holding it low long enough for the
      // oscillator to settle is left to the board
      if (!aresetn) begin
         state_q   <= S_IDLE;
         cnt_q     <= 4'h0;
         cyc_q     <= 4'h0;
         eff_q     <= 8'h00;
         src_q     <= 8'h00;
         rd_addr_q <= 8'h00;
         clk_en_q  <= 1'b1;
      end else begin
         rd_addr_q <= raddr;
         cnt_q     <= busy_w ? cnt_q + 4'h1 : 4'h0;
         case (state_q)
            S_IDLE: begin
               if (start) begin
                  state_q <= op_first(w_data_q[7:0]);
                  cyc_q   <= op_cycles(w_data_q[7:0]);
               end
            end
            S_IND:  state_q <= S_ADR;
            S_ADR: begin
               eff_q   <= mem_byte;
               state_q <= S_SRC;
            end
            S_SRC:  state_q <= S_DST;
            S_DST: begin
               src_q   <= imm_f ? b2 : mem_byte;
               state_q <= S_EXE;
            end
            S_EXE:  state_q <= S_WAIT;
            S_WAIT: begin
               if (cnt_q == cyc_q - 4'h1) begin
                  if (opc == `CFSSE_OPC_STOP) begin
                     state_q  <= S_STOP;
                     clk_en_q <= 1'b0;
                  end else begin
                     state_q <= S_IDLE;
                  end
               end
            end
            // Nothing but reset leaves this state
            S_STOP: state_q <= S_STOP;
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Architectural state: instruction, flags, pointers
   // ---------------------------------------------------------------
   wire [1:0] alu_op = is_sub ? `CFSSE_ALU_SUB :
                       is_ashr ? `CFSSE_ALU_ASHR :
                       (opc == `CFSSE_OPC_SET_CARRY) ? `CFSSE_ALU_SET_CARRY : `CFSSE_ALU_PASS;
   wire       exe    = (state_q == S_EXE);
   wire       ptr_ld = exe && (opc == `CFSSE_OPC_PTR_LOAD);

   always @(posedge aclk) begin
      if (!aresetn) begin
         instr_q    <= 24'h000000;
         flags_q    <= `CFSSE_FLAGS_RST;
         ptr0_q     <= `CFSSE_PTR0_RST;
         ptr1_q     <= `CFSSE_PTR1_RST;
         mem_addr_q <= 8'h00;
         illegal_q  <= 1'b0;
      end else begin
         if (wr_cmd && !wr_lock) begin
            if (w_strb_q[0]) instr_q[7:0]   <= w_data_q[7:0];
            if (w_strb_q[1]) instr_q[15:8]  <= w_data_q[15:8];
            if (w_strb_q[2]) instr_q[23:16] <= w_data_q[23:16];
            illegal_q <= w_strb_q[0] && (op_cycles(w_data_q[7:0]) == 4'h0);
         end
         if (wr_flags && !wr_lock && w_strb_q[0]) begin
            flags_q <= w_data_q[7:0];
         end
         if (wr_maddr && !stopped && w_strb_q[0]) begin
            mem_addr_q <= w_data_q[7:0];
         end
         // Pointer load never reaches the flag register
         if (exe && !ptr_ld) begin
            flags_q <= alu_flags;
         end
         if (mem_we && (mem_wa == `CFSSE_PTR0_ADDR)) begin
            ptr0_q <= mem_wd;
         end
         if (mem_we && (mem_wa == `CFSSE_PTR1_ADDR)) begin
            ptr1_q <= mem_wd;
         end
         if (ptr_ld) begin
            case (b1[1:0])
               2'h2: ptr0_q[7:3] <= b1[7:3];
               2'h1: ptr1_q[7:3] <= b1[7:3];
               2'h0: begin
                  ptr0_q[7:3] <= {b1[7:4], 1'b0};
                  ptr1_q[7:3] <= {b1[7:4], 1'b1};
               end
               default: ptr0_q <= ptr0_q;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // Datapath instances
   // ---------------------------------------------------------------
   cfsse_alu u_alu (
      .op        (alu_op),
      .dst       (mem_byte),
      .src       (src_q),
      .flags_in  (flags_q),
      .result    (alu_res),
      .flags_out (alu_flags)
   );

   cfsse_mem #(
      .AW (8),
      .DW (8)
   ) u_mem (
      .aclk    (aclk),
      .we      (mem_we),
      .waddr   (mem_wa),
      .wdata   (mem_wd),
      .raddr   (raddr),
      .rdata_q (mem_q)
   );

   assign cpu_clk_en = clk_en_q;
   assign sys_clk_en = clk_en_q;
   assign stop_mode  = stopped;
   assign busy       = busy_w;
endmodule

// *** dv/cfsse_exec_properties.sv ***
// Concurrent checks on the ports of the execution slice
`timescale 1ns/100ps
module cfsse_exec_properties (
   input wire        aclk,
   input wire        aresetn,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire        cpu_clk_en,
   input wire        sys_clk_en,
   input wire        stop_mode,
   input wire        busy
);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
   property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data not held");
   property p_w_ans; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid; endproperty
   a_w_ans: assert property (p_w_ans) else $error("write response late");
   property p_r_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_r_ans: assert property (p_r_ans) else $error("read data late");
   property p_clk_off; stop_mode |-> !cpu_clk_en && !sys_clk_en; endproperty
   a_clk_off: assert property (p_clk_off) else $error("clocks run in stop");
   property p_clk_on; !stop_mode |-> cpu_clk_en && sys_clk_en; endproperty
   a_clk_on: assert property (p_clk_on) else $error("clocks off outside stop");
   property p_stay; stop_mode |=> stop_mode && !busy; endproperty
   a_stay: assert property (p_stay) else $error("stop left without reset");
   property p_enter; $rose(stop_mode) |-> $past(busy); endproperty
   a_enter: assert property (p_enter) else $error("stop without instruction");
   property p_busy; $rose(busy) |-> busy [*3] ##[1:8] !busy; endproperty
   a_busy: assert property (p_busy) else $error("execution time wrong");
endmodule
bind cfsse_exec cfsse_exec_properties cfsse_exec_properties_inst (.*);

// *** dv/test_cfsse_exec.sv ***
// Self-checking bench with a reference model of the execution slice
`include "cfsse_defines.vh"
`timescale 1ns/100ps
module test_cfsse_exec;
   logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid, cpu_clk_en, sys_clk_en, stop_mode, busy;
   logic [5:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, rv;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [7:0] m [256];
   logic [7:0] f, d, s, da, sa, ia, op, b1, b2;
   logic [15:0] lf = 16'hDE9E;
   integer miscompares = 0, n_tests = 0, cyc = 0, i, k;
   cfsse_exec cfsse_exec_inst (.*);
   always #5 aclk = ~aclk;
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [7:0] rb();
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      return lf[7:0];
   endfunction
   function logic [7:0] wa(input logic [3:0] n);
      wa = {n[3] ? m[8'hD7][7:3] : m[8'hD6][7:3], n[2:0]};
   endfunction
   task chk(input logic [31:0] g, e);
      n_tests++;
      if (g !== e) begin
         $display("ERROR t=%0t got %h exp %h", $time, g, e);
         miscompares++;
      end
   endtask
   task wr(input logic [5:0] a, input logic [31:0] v);
      logic ha, hw, hb;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(negedge aclk);
         ha = s_axi_awvalid & s_axi_awready;
         hw = s_axi_wvalid & s_axi_wready;
         hb = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge aclk);
         if (ha) s_axi_awvalid <= 0;
         if (hw) s_axi_wvalid <= 0;
      end while (!hb);
      s_axi_bready <= 0;
   endtask
   task rd(input logic [5:0] a);
      logic ha, hr;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
         @(negedge aclk);
         ha = s_axi_arvalid & s_axi_arready;
         hr = s_axi_rvalid;
         rv = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
         if (ha) s_axi_arvalid <= 0;
      end while (!hr);
      s_axi_rready <= 0;
   endtask
   task poke(input logic [7:0] a, v);
      wr(`CFSSE_REG_MEM_ADDR, {24'h0, a});
      wr(`CFSSE_REG_MEM_DATA, {24'h0, v});
      m[a] = v;
   endtask
   task peek(input logic [7:0] a);
      wr(`CFSSE_REG_MEM_ADDR, {24'h0, a});
      rd(`CFSSE_REG_MEM_DATA);
      chk(rv, {24'h0, m[a]});
   endtask
   task cf;
      rd(`CFSSE_REG_FLAGS);
      chk(rv, {24'h0, f});
   endtask
   // Flag write during execution must bounce and leave state alone
   task ex(input logic [7:0] o, x, y);
      wr(`CFSSE_REG_CMD, {8'h0, y, x, o});
      wr(`CFSSE_REG_FLAGS, 32'h55);
      chk(r, `CFSSE_RESP_SLVERR);
      for (k = 0; k < 20 && busy !== 1'b0; k++) @(negedge aclk);
      @(negedge aclk);
      chk(busy, 0);
   endtask
   task print_verdict;
      $display("mismatches %0d, checks %0d", miscompares, n_tests);
      if (miscompares == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         miscompares++;
         print_verdict;
      end
   end
   initial begin
      m[8'hD6] = 8'hC0;
      m[8'hD7] = 8'hC8;
      f = 0;
      repeat (8) @(posedge aclk);
      aresetn <= 1;
      cf;
      peek(8'hD6);
      peek(8'hD7);
      rd(6'h14);
      chk(r, `CFSSE_RESP_SLVERR);
      chk(rv, 32'h0);
      wr(`CFSSE_REG_CMD, 32'h0);
      chk(r, `CFSSE_RESP_OKAY);
      rd(`CFSSE_REG_STATUS);
      chk(rv, 32'h4);
      f = rb() & 8'h7F;
      wr(`CFSSE_REG_FLAGS, {24'h0, f});
      ex(`CFSSE_OPC_SET_CARRY, 0, 0);
      f[7] = 1;
      cf;
      for (i = 0; i < 4; i++) begin
         d = (i == 3) ? 8'h01 : rb();
         f = rb();
         da = i[0] ? 8'h12 : 8'h10;
         poke(8'h11, 8'h12);
         poke(da, d);
         wr(`CFSSE_REG_FLAGS, {24'h0, f});
         ex(i[0] ? `CFSSE_OPC_ASHR_IND : `CFSSE_OPC_ASHR_DIR, 8'h10 | i[0], 0);
         m[da] = {d[7], d[7:1]};
         f = {d[0], m[da] == 0, d[7], 1'b0, f[3:0]};
         peek(da);
         cf;
      end
      // Last pass parks the pointers at 40/48 for the subtract loop
      for (i = 0; i < 5; i++) begin
         s = rb();
         d = (i == 4) ? 8'h40 : {s[7:2], i[1:0]};
         if (d[1:0] == 2'b10) m[8'hD6][7:3] = d[7:3];
         if (d[1:0] == 2'b01) m[8'hD7][7:3] = d[7:3];
         if (d[1:0] == 2'b00) m[8'hD6][7:3] = {d[7:4], 1'b0};
         if (d[1:0] == 2'b00) m[8'hD7][7:3] = {d[7:4], 1'b1};
         ex(`CFSSE_OPC_PTR_LOAD, d, 0);
         peek(8'hD6);
         peek(8'hD7);
         cf;
      end
      for (i = 0; i < 15; i++) begin
         op = 8'h22 + i % 5;
         d = rb();
         s = (i == 14) ? d : rb();
         k = rb();
         ia = 8'h30 | k[2:0];
         if (op < 8'h24) begin
            b1 = {1'b0, k[6:4], 1'b1, k[2:0]};
            da = wa(b1[7:4]);
            sa = wa(b1[3:0]);
         end else begin
            b1 = (op == 8'h26) ? (8'h20 | k[6:4]) : (8'h28 | k[2:0]);
            da = (op == 8'h26) ? b1 : (8'h20 | k[6:4]);
            sa = b1;
         end
         b2 = (op == 8'h26) ? s : da;
         if (op[0]) poke(sa, ia);
         if (op[0]) sa = ia;
         poke(da, d);
         if (op != 8'h26) poke(sa, s);
         f = rb();
         wr(`CFSSE_REG_FLAGS, {24'h0, f});
         ex(op, b1, b2);
         m[da] = d - s;
         f = {d < s, m[da] == 0, m[da][7], d[7] != s[7] && m[da][7] == s[7], 1'b1, d[3:0] < s[3:0], f[1:0]};
         peek(da);
         if (op != 8'h26) peek(sa);
         cf;
      end
      ex(`CFSSE_OPC_STOP, 0, 0);
      chk({stop_mode, cpu_clk_en, sys_clk_en}, 3'b100);
      repeat (20) @(posedge aclk);
      cf;
      chk(stop_mode, 1);
      aresetn <= 0;
      repeat (8) @(posedge aclk);
      aresetn <= 1;
      m[8'hD6] = 8'hC0;
      m[8'hD7] = 8'hC8;
      f = 0;
      @(negedge aclk);
      chk({stop_mode, cpu_clk_en, sys_clk_en}, 3'b011);
      peek(da);
      cf;
      peek(8'hD6);
      print_verdict;
   end
endmodule
